// *** rtl/decode_pkg.sv ***
// Purpose: Shared constants of the compute and memory access decoder
// Assumes: 48-bit instruction words, 32 index/modify registers behind a plain port
// Notes: Field positions are the low bit of each field unless noted
package decode_pkg;
	localparam int INSTR_W = 48;
	localparam int COMP_W = 23;
	localparam int CONDITION_FIELD_W = 5;
	localparam int UREG_W = 7;
	localparam int DREG_W = 4;
	localparam int DATA_W = 6;
	localparam int REGA_W = 8;
	localparam int RF_IDX_W = 5;
	localparam int RF_DEPTH = 32;
	// Opcode decode
	localparam int OPC_LO = 45;
	localparam logic [2:0] OPC_UREG = 3'h2;
	localparam logic [2:0] OPC_IMM = 3'h3;
	localparam int IMM_ZERO_POS = 44;
	localparam int CONDITION_FIELD_LO = 33;
	// Universal-register memory format
	localparam int T3_U_POS = 44;
	localparam int T3_I_LO = 41;
	localparam int T3_M_LO = 38;
	localparam int T3_G_POS = 32;
	localparam int T3_D_POS = 31;
	localparam int T3_L_POS = 30;
	localparam int T3_UREG_LO = 23;
	// Immediate-modify format
	localparam int T4_I_LO = 41;
	localparam int T4_G_POS = 40;
	localparam int T4_D_POS = 39;
	localparam int T4_U_POS = 38;
	localparam int T4_DATA_LO = 27;
	localparam int T4_DREG_LO = 23;
	// Field encodings
	localparam logic [4:0] CONDITION_FIELD_TRUE = 5'h1f;
	localparam logic DIR_WRITE = 1'b1;
	localparam logic UPD_POST = 1'b1;
	localparam logic [2:0] BCAST_IDX = 3'h1;
	// Register map, byte addresses
	localparam logic [7:0] REG_IDX_BASE = 8'h00;
	localparam logic [7:0] REG_MOD_BASE = 8'h40;
	localparam logic [7:0] REG_MAP_END = 8'h7c;
	localparam logic [31:0] REG_RST = 32'h0000_0000;
endpackage

// *** rtl/regfile_if.sv ***
// Purpose: Ports of the index/modify register store
// Assumes: Three read ports, two write ports
// Notes: Write port 0 has priority over port 1 on the same word
`timescale 1ns/1ps
interface regfile_if #(parameter int A = 5, parameter int W = 32);
	logic [A-1:0] raddr [3];
	logic ren [3];
	logic [W-1:0] rdata [3];
	logic we [2];
	logic [A-1:0] waddr [2];
	logic [W-1:0] wdata [2];
	modport user (output raddr, ren, we, waddr, wdata, input rdata);
	modport store (input raddr, ren, we, waddr, wdata, output rdata);
endinterface

// *** rtl/index_modify_regfile.sv ***
// Purpose: Index and modify register store with registered read data
// Assumes: Read data stand one cycle after the read enable, zero otherwise
// Notes: Clock enable low freezes all contents and read data
`timescale 1ns/1ps
module index_modify_regfile #(
	parameter int DEPTH = 32,
	parameter int A = 5,
	parameter int W = 32
) (
	input wire logic clk_i,     // Core clock
	input wire logic nrst_i,    // Async reset, active low
	input wire logic ce_i,      // Clock enable
	regfile_if.store rf         // Store ports
);
	logic [W-1:0] mem_q [DEPTH];

	if (DEPTH > (1 << A))
	begin : g_chk
		$error("Depth does not fit the address width");
	end

	// Write ports, port 0 applied last so it wins
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (int k = 0; k < DEPTH; k++)
				mem_q[k] <= decode_pkg::REG_RST[W-1:0];
		end
		else if (ce_i)
		begin
			if (rf.we[1])
				mem_q[rf.waddr[1]] <= rf.wdata[1];
			if (rf.we[0])
				mem_q[rf.waddr[0]] <= rf.wdata[0];
		end
	end

	// Registered read ports
	for (genvar p = 0; p < 3; p++)
	begin : g_rd
		logic [W-1:0] rdata_q;
		always_ff @(posedge clk_i or negedge nrst_i)
		begin
			if (!nrst_i)
				rdata_q <= '0;
			else if (ce_i)
				rdata_q <= rf.ren[p] ? mem_q[rf.raddr[p]] : '0;
		end
		assign rf.rdata[p] = rdata_q;
	end
endmodule

// *** rtl/compute_memory_access_decode.sv ***
// Purpose: Decode and execute the register-modify and immediate-modify memory formats
// Assumes: Instruction, mode bits and condition flags come from core-clock logic
// Notes: Two-stage pipe; results stand two enabled cycles after the instruction, unknown_o one enabled cycle after it
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module compute_memory_access_decode #(
	parameter int AW = 32
) (
	input wire logic clk_i,                          // Core clock, 25 MHz
	input wire logic nrst_i,                         // Async reset, active low
	input wire logic ce_i,                           // Clock enable, freezes state when low
	input wire logic [47:0] instr_i,                 // Instruction word
	input wire logic instr_valid_i,                  // Instruction valid pulse
	input wire logic dual_lane_mode_i,               // Dual-lane mode bit
	input wire logic broadcast_read_index_one_i,     // Broadcast read for I1
	input wire logic broadcast_read_index_nine_i,    // Broadcast read for I9
	input wire logic [31:0] x_condition_field_flags_i,          // X lane condition results by code
	input wire logic [31:0] y_condition_field_flags_i,          // Y lane condition results by code
	input wire logic [7:0] reg_addr_i,               // Register byte address
	input wire logic [AW-1:0] reg_wdata_i,           // Register write data
	input wire logic reg_wr_i,                       // Register write strobe
	input wire logic reg_rd_i,                       // Register read strobe
	output logic [AW-1:0] reg_rdata_o,               // Register read data, cycle after strobe
	output logic mem_req_o,                          // Memory access pulse
	output logic mem_write_o,                        // 1 writes register to memory
	output logic mem_pm_o,                           // 1 program memory space
	output logic mem_long_o,                         // Forced long-word access
	output logic [AW-1:0] x_addr_o,                  // X lane address
	output logic [AW-1:0] y_addr_o,                  // Y lane address
	output logic x_lane_en_o,                        // X lane executes
	output logic y_lane_en_o,                        // Y lane executes
	output logic [6:0] xfer_reg_o,                   // Register code of the transfer
	output logic xfer_ureg_o,                        // 1 universal, 0 data register
	output logic [22:0] compute_o,                   // Compute field
	output logic compute_x_en_o,                     // Compute runs in X lane
	output logic compute_y_en_o,                     // Compute runs in Y lane
	output logic unknown_o                           // Valid word of another format
);
	regfile_if #(.A(decode_pkg::RF_IDX_W), .W(AW)) rf ();

	logic is_t3, is_t4, dec_g, dec_d, dec_u, dec_l;
	logic [2:0] dec_i, dec_m;
	logic [decode_pkg::CONDITION_FIELD_W-1:0] dec_condition_field;
	logic [6:0] dec_reg;
	logic [AW-1:0] dec_imm;
	logic accept;
	logic s1_v_q, s1_t4_q, s1_g_q, s1_d_q, s1_u_q, s1_l_q, s1_xok_q, s1_yok_q, s1_bc_q;
	logic [2:0] s1_i_q;
	logic [6:0] s1_reg_q;
	logic [AW-1:0] s1_imm_q;
	logic [22:0] s1_comp_q;
	logic wb_v_q;
	logic [3:0] wb_idx_q;
	logic [AW-1:0] wb_val_q;
	logic [AW-1:0] ival, modv, ybase, x_addr, y_addr, new_i;
	logic exec, wb_en, reg_map;

	if (AW < 8 || AW > 32)
	begin : g_chk
		$error("Address width must be 8 to 32");
	end

	// Condition test, code all ones is always true
	function automatic logic condition_field_ok(input logic [4:0] code, input logic [31:0] flags);
		condition_field_ok = (code == decode_pkg::CONDITION_FIELD_TRUE) || flags[code];
	endfunction

	// Field extraction for both formats
	always_comb
	begin
		is_t3 = instr_i[47:decode_pkg::OPC_LO] == decode_pkg::OPC_UREG;
		is_t4 = instr_i[47:decode_pkg::OPC_LO] == decode_pkg::OPC_IMM && !instr_i[decode_pkg::IMM_ZERO_POS];
		dec_condition_field = instr_i[decode_pkg::CONDITION_FIELD_LO +: decode_pkg::CONDITION_FIELD_W];
		dec_i = instr_i[decode_pkg::T3_I_LO +: 3];
		dec_m = instr_i[decode_pkg::T3_M_LO +: 3];
		dec_g = is_t4 ? instr_i[decode_pkg::T4_G_POS] : instr_i[decode_pkg::T3_G_POS];
		dec_d = is_t4 ? instr_i[decode_pkg::T4_D_POS] : instr_i[decode_pkg::T3_D_POS];
		dec_u = is_t4 ? instr_i[decode_pkg::T4_U_POS] : instr_i[decode_pkg::T3_U_POS];
		dec_l = !is_t4 && instr_i[decode_pkg::T3_L_POS];
		dec_reg = is_t4 ? {3'h0, instr_i[decode_pkg::T4_DREG_LO +: decode_pkg::DREG_W]}
			: instr_i[decode_pkg::T3_UREG_LO +: decode_pkg::UREG_W];
		dec_imm = AW'($signed(instr_i[decode_pkg::T4_DATA_LO +: decode_pkg::DATA_W]));
		accept = ce_i && instr_valid_i && (is_t3 || is_t4);
	end

	// Store ports: index and modify reads, write-back and bus write
	always_comb
	begin
		reg_map = reg_addr_i <= decode_pkg::REG_MAP_END;
		rf.raddr[0] = {1'b0, dec_g, dec_i};
		rf.raddr[1] = {1'b1, dec_g, dec_m};
		rf.raddr[2] = reg_addr_i[6:2];
		rf.ren[0] = accept;
		rf.ren[1] = accept && !is_t4;
		rf.ren[2] = reg_rd_i && reg_map;
		rf.we[0] = wb_en;
		rf.waddr[0] = {1'b0, s1_g_q, s1_i_q};
		rf.wdata[0] = new_i;
		rf.we[1] = reg_wr_i && reg_map;
		rf.waddr[1] = reg_addr_i[6:2];
		rf.wdata[1] = reg_wdata_i;
	end

	index_modify_regfile #(.DEPTH(decode_pkg::RF_DEPTH), .A(decode_pkg::RF_IDX_W), .W(AW)) u_rf (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.rf(rf.store)
	);

	// Read data come straight from the store's read register
	assign reg_rdata_o = rf.rdata[2];

	// Stage 1 capture of decoded fields and lane conditions
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s1_v_q <= 1'b0;
			s1_t4_q <= 1'b0;
			s1_g_q <= 1'b0;
			s1_d_q <= 1'b0;
			s1_u_q <= 1'b0;
			s1_l_q <= 1'b0;
			s1_i_q <= 3'h0;
			s1_reg_q <= 7'h00;
			s1_imm_q <= '0;
			s1_comp_q <= 23'h000000;
			s1_xok_q <= 1'b0;
			s1_yok_q <= 1'b0;
			s1_bc_q <= 1'b0;
		end
		else if (ce_i)
		begin
			s1_v_q <= accept;
			s1_t4_q <= is_t4;
			s1_g_q <= dec_g;
			s1_d_q <= dec_d;
			s1_u_q <= dec_u;
			s1_l_q <= dec_l;
			s1_i_q <= dec_i;
			s1_reg_q <= dec_reg;
			s1_imm_q <= dec_imm;
			s1_comp_q <= instr_i[decode_pkg::COMP_W-1:0];
			s1_xok_q <= condition_field_ok(dec_condition_field, x_condition_field_flags_i);
			s1_yok_q <= dual_lane_mode_i && condition_field_ok(dec_condition_field, y_condition_field_flags_i);
			s1_bc_q <= dual_lane_mode_i && dec_i == decode_pkg::BCAST_IDX
				&& (dec_g ? broadcast_read_index_nine_i : broadcast_read_index_one_i);
		end
	end

	// Address arithmetic; a just-written index is forwarded
	always_comb
	begin
		ival = (wb_v_q && wb_idx_q == {s1_g_q, s1_i_q}) ? wb_val_q : rf.rdata[0];
		modv = s1_t4_q ? s1_imm_q : rf.rdata[1];
		ybase = s1_bc_q ? ival : ival + AW'(1);
		new_i = ival + modv;
		x_addr = (s1_u_q == decode_pkg::UPD_POST) ? ival : new_i;
		y_addr = (s1_u_q == decode_pkg::UPD_POST) ? ybase : ybase + modv;
		exec = s1_v_q && (s1_xok_q || s1_yok_q);
		wb_en = exec && s1_u_q == decode_pkg::UPD_POST;
	end

	// Forwarding record of the last write-back
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wb_v_q <= 1'b0;
			wb_idx_q <= 4'h0;
			wb_val_q <= '0;
		end
		else if (ce_i)
		begin
			wb_v_q <= wb_en;
			wb_idx_q <= {s1_g_q, s1_i_q};
			wb_val_q <= new_i;
		end
	end

	// Access and lane outputs
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mem_req_o <= 1'b0;
			mem_write_o <= 1'b0;
			mem_pm_o <= 1'b0;
			mem_long_o <= 1'b0;
			x_addr_o <= '0;
			y_addr_o <= '0;
			x_lane_en_o <= 1'b0;
			y_lane_en_o <= 1'b0;
			xfer_reg_o <= 7'h00;
			xfer_ureg_o <= 1'b0;
		end
		else if (ce_i)
		begin
			mem_req_o <= exec;
			mem_write_o <= s1_d_q == decode_pkg::DIR_WRITE;
			mem_pm_o <= s1_g_q;
			mem_long_o <= s1_l_q;
			x_addr_o <= x_addr;
			y_addr_o <= y_addr;
			x_lane_en_o <= s1_v_q && s1_xok_q;
			y_lane_en_o <= s1_v_q && s1_yok_q;
			xfer_reg_o <= s1_reg_q;
			xfer_ureg_o <= !s1_t4_q;
		end
	end

	// Compute field handed on in parallel with the access
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			compute_o <= 23'h000000;
			compute_x_en_o <= 1'b0;
			compute_y_en_o <= 1'b0;
			unknown_o <= 1'b0;
		end
		else if (ce_i)
		begin
			compute_o <= s1_comp_q;
			compute_x_en_o <= s1_v_q && s1_xok_q;
			compute_y_en_o <= s1_v_q && s1_yok_q;
			unknown_o <= instr_valid_i && !(is_t3 || is_t4);
		end
	end

	// Checks run on the core clock and rest while reset is low
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	// Condition code of the word at the input
	logic [4:0] in_condition_field;
	assign in_condition_field = instr_i[decode_pkg::CONDITION_FIELD_LO +: 5];

	opcode_accept_a: assert property ((accept && !instr_i[decode_pkg::OPC_LO]
		&& in_condition_field == decode_pkg::CONDITION_FIELD_TRUE) ##1 ce_i |=> mem_req_o && xfer_ureg_o)
		else $error("Register-modify word gave no access");
	imm_format_a: assert property ((ce_i && instr_valid_i && instr_i[47:44] == 4'h7)
		|=> (unknown_o and (ce_i |=> !mem_req_o))) else $error("Word with bit 44 set taken as immediate format");
	dir_space_a: assert property ((accept && in_condition_field == decode_pkg::CONDITION_FIELD_TRUE) ##1 ce_i
		|=> mem_write_o == $past(dec_d, 2) && mem_pm_o == $past(dec_g, 2)) else $error("Direction or space wrong");
	long_word_a: assert property ((accept && is_t3) ##1 ce_i
		|=> mem_long_o == $past(instr_i[30], 2)) else $error("Long-word bit not carried");
	pre_no_update_a: assert property (s1_v_q && s1_u_q != decode_pkg::UPD_POST |-> !rf.we[0])
		else $error("Pre-modify updated the index");
	post_update_a: assert property ((exec && s1_u_q == decode_pkg::UPD_POST && ce_i)
		|=> x_addr_o + $past(modv) == $past(new_i)) else $error("Post-modify address not the old index");
	false_condition_field_a: assert property ((accept && in_condition_field != decode_pkg::CONDITION_FIELD_TRUE && !x_condition_field_flags_i[in_condition_field]
		&& !y_condition_field_flags_i[in_condition_field]) ##1 ce_i |=> !mem_req_o && !compute_x_en_o && !compute_y_en_o)
		else $error("False condition still executed");
	y_offset_a: assert property ((ce_i && s1_v_q && !s1_bc_q && s1_u_q == decode_pkg::UPD_POST)
		|=> y_addr_o == x_addr_o + AW'(1)) else $error("Y lane address not index plus one");
	bcast_same_a: assert property ((ce_i && s1_v_q && s1_bc_q) |=> y_addr_o == x_addr_o)
		else $error("Broadcast read used a different Y address");
	single_lane_a: assert property ((accept && !dual_lane_mode_i) ##1 ce_i |=> !y_lane_en_o && !compute_y_en_o)
		else $error("Y lane ran in single-lane mode");
	compute_pass_a: assert property ((accept ##1 ce_i) |=> compute_o == $past(instr_i[22:0], 2))
		else $error("Compute field not passed on");
	x_condition_field_a: assert property ((accept && condition_field_ok(in_condition_field, x_condition_field_flags_i)) ##1 ce_i
		|=> x_lane_en_o && compute_x_en_o) else $error("X lane skipped a true condition");
	y_condition_field_a: assert property ((accept && dual_lane_mode_i && condition_field_ok(in_condition_field, y_condition_field_flags_i)) ##1 ce_i
		|=> y_lane_en_o && compute_y_en_o) else $error("Y lane skipped a true condition");
	ureg_code_a: assert property ((accept && is_t3) ##1 ce_i
		|=> xfer_reg_o == $past(instr_i[29:23], 2) && xfer_ureg_o) else $error("Universal register code wrong");
	dreg_code_a: assert property ((accept && is_t4) ##1 ce_i
		|=> xfer_reg_o == {3'h0, $past(instr_i[26:23], 2)} && !xfer_ureg_o) else $error("Data register code wrong");
	imm_no_long_a: assert property ((accept && is_t4) ##1 ce_i |=> !mem_long_o)
		else $error("Immediate format forced a long word");
	y_pre_offset_a: assert property ((ce_i && s1_v_q && !s1_bc_q && s1_u_q != decode_pkg::UPD_POST)
		|=> y_addr_o == x_addr_o + AW'(1)) else $error("Pre-modified Y address not index plus one");

	// Main scenarios to be reached
	dual_lane_c: cover property (mem_req_o && x_lane_en_o && y_lane_en_o);
	long_word_c: cover property (mem_req_o && mem_long_o);
	split_condition_field_c: cover property (mem_req_o && !x_lane_en_o && y_lane_en_o);
	imm_post_c: cover property (exec && s1_t4_q && s1_u_q == decode_pkg::UPD_POST);
	broadcast_c: cover property (s1_v_q && s1_bc_q);
endmodule

// *** verification/mem_model.sv ***
// Purpose: Far-side memory port model that counts lane transfers
// Assumes: Lane enables are one-cycle pulses beside mem_req_o
// Notes: Counts are read by the bench after the last instruction test
`timescale 1ns/1ps
module mem_model (
	input wire logic clk_i,          // Core clock
	input wire logic nrst_i,         // Async reset, active low
	input wire logic mem_req_i,      // Access pulse from the decoder
	input wire logic x_lane_en_i,    // X lane executes
	input wire logic y_lane_en_i,    // Y lane executes
	output int x_count_o,            // X lane transfers seen
	output int y_count_o             // Y lane transfers seen
);
	// Each lane takes its own transfer only while an access is requested
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			x_count_o <= 0;
			y_count_o <= 0;
		end
		else if (mem_req_i)
		begin
			x_count_o <= x_count_o + int'(x_lane_en_i);
			y_count_o <= y_count_o + int'(y_lane_en_i);
		end
	end
endmodule

// *** verification/compute_memory_access_decode_tb_top.sv ***
// Purpose: Self-checking bench for the compute and memory access decoder
// Assumes: Clock enable stays high except in the final freeze test; register port answers one cycle after a read
// Notes: Index and modify registers are set over the register port; index registers are read back over it
`timescale 1ns/1ps
module compute_memory_access_decode_tb_top;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b1;
	logic [47:0] instr_i = 48'h0;
	logic instr_valid_i = 1'b0;
	logic dual_i = 1'b0;
	logic b1_i = 1'b0;
	logic b9_i = 1'b0;
	logic [31:0] xf_i = 32'h0;
	logic [31:0] yf_i = 32'h0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] rdata, xa, ya, rd;
	logic req, wrt, pm, lng, xen, yen, uflag, cxe, cye, unk, unk1;
	logic [6:0] xreg;
	logic [22:0] comp;
	int xcnt, ycnt, cycles;
	int mismatches = 0;
	int check_count = 0;
	compute_memory_access_decode DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .instr_i(instr_i),
		.instr_valid_i(instr_valid_i), .dual_lane_mode_i(dual_i), .broadcast_read_index_one_i(b1_i),
		.broadcast_read_index_nine_i(b9_i), .x_condition_field_flags_i(xf_i), .y_condition_field_flags_i(yf_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(rdata), .mem_req_o(req), .mem_write_o(wrt), .mem_pm_o(pm), .mem_long_o(lng),
		.x_addr_o(xa), .y_addr_o(ya), .x_lane_en_o(xen), .y_lane_en_o(yen), .xfer_reg_o(xreg),
		.xfer_ureg_o(uflag), .compute_o(comp), .compute_x_en_o(cxe), .compute_y_en_o(cye), .unknown_o(unk));
	mem_model partner (.clk_i(clk_i), .nrst_i(nrst_i), .mem_req_i(req), .x_lane_en_i(xen),
		.y_lane_en_i(yen), .x_count_o(xcnt), .y_count_o(ycnt));
	// Core clock, 25 MHz
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	// Hang guard
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			mismatches = mismatches + 1;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 rd = rdata;
	endtask
	// Issues one instruction and samples its outputs one edge after it is taken, unknown_o just after it is taken
	task automatic exec(input logic [47:0] w, input logic d, b1, b9, input logic [31:0] xf, yf);
		@(posedge clk_i);
		instr_i <= w;
		instr_valid_i <= 1'b1;
		dual_i <= d;
		b1_i <= b1;
		b9_i <= b9;
		xf_i <= xf;
		yf_i <= yf;
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		#1 unk1 = unk;
		@(posedge clk_i);
		#1;
	endtask
	function automatic logic [47:0] t3(input logic u, input logic [2:0] i, m, input logic [4:0] c,
		input logic g, dr, l, input logic [6:0] ur);
		t3 = {3'h2, u, i, m, c, g, dr, l, ur, 23'h000abc};
	endfunction
	function automatic logic [47:0] t4(input logic [2:0] i, input logic g, dr, u, input logic [4:0] c,
		input logic [5:0] dt, input logic [3:0] r);
		t4 = {3'h3, 1'b0, i, g, dr, u, c, dt, r, 23'h000abc};
	endfunction
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		reg_write(8'h00, 32'h100);
		reg_write(8'h04, 32'h200);
		reg_write(8'h24, 32'h300);
		reg_write(8'h44, 32'h4);
		reg_read(8'h00);
		chk(rd, 32'h100);
		reg_read(8'h80);
		chk(rd, 32'h0);
		$display("Test register port done");
		// Post-modify write, forced long word; ureg code is a data register, not an index/modify one
		exec(t3(1'b1, 3'h0, 3'h1, 5'h1f, 1'b0, 1'b1, 1'b1, 7'h05), 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
		chk({req, wrt, pm, lng, uflag, cxe, cye}, 7'b1101110);
		chk(xa, 32'h100);
		chk({25'h0, xreg}, 32'h5);
		chk({9'h0, comp}, 32'h000abc);
		reg_read(8'h00);
		chk(rd, 32'h100 + 32'h4);
		$display("Test post-modify done");
		// Pre-modify read in dual-lane mode
		exec(t3(1'b0, 3'h0, 3'h1, 5'h1f, 1'b0, 1'b0, 1'b0, 7'h05), 1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
		chk({req, wrt, lng, xen, yen, cxe, cye}, 7'b1001111);
		chk(xa, 32'h104 + 32'h4);
		chk(ya, 32'h104 + 32'h1 + 32'h4);
		reg_read(8'h00);
		chk(rd, 32'h104);
		$display("Test pre-modify done");
		// Immediate format, negative offset, program space, broadcast on index nine
		exec(t4(3'h1, 1'b1, 1'b0, 1'b0, 5'h1f, 6'h3e, 4'h3), 1'b1, 1'b0, 1'b1, 32'h0, 32'h0);
		chk({req, pm, uflag, lng}, 4'b1100);
		chk(xa, 32'h300 - 32'h2);
		chk(ya, 32'h300 - 32'h2);
		chk({25'h0, xreg}, 32'h3);
		$display("Test immediate broadcast done");
		// Post-modify where only the Y lane tests true
		exec(t4(3'h1, 1'b0, 1'b1, 1'b1, 5'h05, 6'h05, 4'h2), 1'b1, 1'b0, 1'b0, 32'h0, 32'h20);
		chk({req, xen, yen, cxe, cye}, 5'b10101);
		chk(xa, 32'h200);
		chk(ya, 32'h200 + 32'h1);
		reg_read(8'h04);
		chk(rd, 32'h200 + 32'h5);
		$display("Test per-lane condition done");
		// Both lanes false: nothing executes and the index stays
		exec(t4(3'h1, 1'b0, 1'b0, 1'b1, 5'h05, 6'h05, 4'h2), 1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
		chk({req, xen, yen, cxe, cye}, 5'b00000);
		reg_read(8'h04);
		chk(rd, 32'h205);
		$display("Test false condition done");
		// Post-modify on index one with its broadcast bit: Y keeps the index
		exec(t3(1'b1, 3'h1, 3'h1, 5'h1f, 1'b0, 1'b0, 1'b0, 7'h05), 1'b1, 1'b1, 1'b0, 32'h0, 32'h0);
		chk(xa, 32'h205);
		chk(ya, 32'h205);
		reg_read(8'h04);
		chk(rd, 32'h205 + 32'h4);
		$display("Test broadcast index one done");
		// Another format is flagged and nothing else
		exec(48'h7000_0000_0000, 1'b1, 1'b0, 1'b0, 32'hffff_ffff, 32'hffff_ffff);
		chk({unk1, req}, 2'b10);
		chk(xcnt, 4);
		chk(ycnt, 4);
		$display("Test other format done");
		// Clock enable low freezes the read data register
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= 8'h04;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		ce_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1 chk(rdata, 32'h209);
		@(posedge clk_i);
		ce_i <= 1'b1;
		@(posedge clk_i);
		#1 chk(rdata, 32'h0);
		$display("Test clock enable done");
		wrap_up();
	end
endmodule
